// ---- rtl/hlt_pkg.sv ----
// constants shared by the hardware limit timer block
// assumes one system clock; the timer clock arrives as a tick enable
package hlt_pkg;
  // register byte offsets on the axi4-lite slave
  localparam int unsigned AW          = 8;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD = 8'h04;
  localparam logic [7:0]  ADDR_PWCMP  = 8'h08;
  localparam logic [7:0]  ADDR_COUNT  = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS = 8'h10;
  // control word fields
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_MODE_LSB  = 8;
  localparam int CTRL_PRESCALER_SYNC_ENABLE_BIT = 16;
  localparam int CTRL_CLK_LSB   = 20;
  // status word fields
  localparam int STAT_RUN_BIT   = 0;
  localparam int STAT_PWM_BIT   = 1;
  localparam int STAT_ERS_BIT   = 2;
  localparam int STAT_HOLD_BIT  = 3;
  // reset values
  localparam logic [4:0] MODE_RST   = 5'h00;
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] PWCMP_RST  = 8'h00;
  // timer clock source codes
  localparam logic [1:0] CLK_OTHER = 2'h0;
  localparam logic [1:0] CLK_LOW   = 2'h1;
  localparam logic [1:0] CLK_MID   = 2'h2;
  localparam logic [1:0] CLK_HIGH  = 2'h3;
  // hardware reset delay in timer clocks
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operating modes; every other code is reserved
  typedef enum logic [4:0] {
    HLT_M_LVL_LO = 5'b00110,
    HLT_M_LVL_HI = 5'b00111,
    HLT_M_SW     = 5'b01000,
    HLT_M_EOS_R  = 5'b01001,
    HLT_M_EOS_F  = 5'b01010,
    HLT_M_EOS_A  = 5'b01011,
    HLT_M_EHL_R  = 5'b01100,
    HLT_M_EHL_F  = 5'b01101,
    HLT_M_LEO_LO = 5'b01110,
    HLT_M_LEO_HI = 5'b01111,
    HLT_M_MONO_R = 5'b10001,
    HLT_M_MONO_F = 5'b10010,
    HLT_M_MONO_A = 5'b10011,
    HLT_M_LOS_LO = 5'b10110,
    HLT_M_LOS_HI = 5'b10111
  } hlt_mode_e;
endpackage

// ---- rtl/hlt_edge_det.sv ----
// edge detector for the external reset/trigger level
// assumes the input is synchronous to the system clock
`timescale 1ns/10ps
`default_nettype none
module hlt_edge_det (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  // level in, edges out
  input  wire logic i_sig,
  output logic      o_rise,
  output logic      o_fall
);
  logic prev_q;

  // previous level, advanced only on timer ticks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= 1'b0;
    end else if (i_en) begin
      prev_q <= i_sig;
    end
  end

  // edges relative to the last tick
  assign o_rise = i_sig & ~prev_q;
  assign o_fall = ~i_sig & prev_q;
endmodule // hlt_edge_det
`default_nettype wire

// ---- rtl/hlt_pwm_drive.sv ----
// pwm drive flop for the companion compare unit
// assumes start, advance and kill are sampled on timer ticks
`timescale 1ns/10ps
`default_nettype none
module hlt_pwm_drive #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_en,
  // control from the timer
  input  wire logic         i_start,
  input  wire logic         i_adv,
  input  wire logic         i_kill,
  input  wire logic [W-1:0] i_count,
  input  wire logic [W-1:0] i_cmp,
  // drive out
  output logic              o_drive
);
  // start beats compare so a restart on the match tick is kept
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drive <= 1'b0;
    end else if (i_en) begin
      if (i_kill) begin
        o_drive <= 1'b0;
      end else if (i_start) begin
        o_drive <= 1'b1;
      // RULE_07: compare match ends
      end else if (i_adv && i_count == i_cmp) begin
        o_drive <= 1'b0;
      end
    end
  end

  // RULE_13: drive ends at compare
  pwm_end_a: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_07
    i_en && !i_kill && !i_start && i_adv && i_count == i_cmp |=> !o_drive)
    else $error("pwm drive did not end at compare match");
endmodule // hlt_pwm_drive
`default_nettype wire

// ---- rtl/hlt_timer.sv ----
// hardware limit timer mode control with axi4-lite registers
// assumes i_timer_tick is the selected timer clock as a one-cycle enable
// Functional notes
// RULE_01: 00110 holds count reset on low trigger, 00111 on high.
// RULE_02: with on bit clear, level limit modes ignore the trigger.
// RULE_03: level limit clears on period match or two clocks into reset.
// RULE_04: counting and pwm resume after match or two clocks after release.
// RULE_05: pwm falls only at compare; reset while high keeps it high.
// RULE_06: 01000 one shot: match clears count and on; software restarts.
// RULE_07: software one shot pwm starts on set, ends at compare.
// RULE_08: clearing on pauses; fresh cycle only after match cleared on.
// RULE_09: 01001/01010/01011 start on rise/fall/any edge, match clears on.
// RULE_10: after on cleared, a new edge is needed to resume.
// RULE_11: 01100/01101 first edge starts, later edges reset, resume two clocks.
// RULE_12: match clears count and on; edges ignored while on clear.
// RULE_13: starting and reset edges start pwm; compare ends it.
// RULE_14: 01110/01111 level reset, count from leaving it, match clears on.
// RULE_15: new start edge needed after on clears; pwm starts on edge.
// RULE_16: 10001/10010/10011 monostable start on edge, stop at match.
// RULE_17: monostable halts at zero after match, on stays set.
// RULE_18: monostable pwm starts on start edge only.
// RULE_19: 10110/10111 held at reset level; count when on and released.
// RULE_20: match clears count and on; stays reset until both conditions.
// RULE_21: pwm starts on whichever event starts the timer.
// RULE_22: prescaler sync set: frozen in sleep, values kept.
// RULE_23: prescaler sync clear: runs in sleep, chosen oscillator kept on.
// RULE_24: reserved codes keep the counter cleared and idle.
`timescale 1ns/10ps
`default_nettype none
module hlt_timer
  import hlt_pkg::*;
#(
  parameter int W = 8
) (
  // clock, reset, enable
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_clk_en,
  // timer clock, sleep and trigger
  input  wire logic                 i_timer_tick,
  input  wire logic                 i_sleep,
  input  wire logic                 i_external_reset_trigger,
  // axi4-lite write
  input  wire logic [hlt_pkg::AW-1:0] i_awaddr,
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  // axi4-lite read
  input  wire logic [hlt_pkg::AW-1:0] i_araddr,
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  // timer outputs
  output logic                      o_pwm_drive,
  output logic [W-1:0]              o_count_value,
  output logic                      o_on,
  output logic                      o_keep_low_freq_internal_osc,
  output logic                      o_keep_mid_freq_internal_osc,
  output logic                      o_keep_high_freq_internal_osc
);
  import hlt_pkg::*;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  logic [4:0]   mode_q;
  logic [W-1:0] period_value_q, pulse_width_compare_q, cnt_q, cnt_d;
  logic         prescaler_sync_enable_q, on_q, on_prev_q, run_q, run_d, clr_on;
  logic [1:0]   clk_src_q, hold_q, hold_d, asrt_q, asrt_d;
  logic         adv, pwm_go, idle, tk, rise, fall, edge_sel, rst_lvl, match;
  logic [AW-1:0] awaddr_q;
  logic [31:0]  wdata_q, rd_d;
  logic [3:0]   wstrb_q;
  logic         aw_full_q, w_full_q, do_wr, ctrl_on_wr;
  hlt_mode_e    mode_e;

  assign mode_e = hlt_mode_e'(mode_q);
  // RULE_22: no timer ticks in sleep when synced
  assign tk     = i_clk_en & i_timer_tick & ~(i_sleep & prescaler_sync_enable_q);
  assign match  = cnt_q == period_value_q;
  assign do_wr  = i_clk_en & aw_full_q & w_full_q & ~o_bvalid;
  assign ctrl_on_wr = do_wr && awaddr_q == ADDR_CTRL && wstrb_q[0];
  assign o_count_value = cnt_q;
  assign o_on          = on_q;

  hlt_edge_det u_edge (
    .i_clk  (i_sys_clk),
    .i_rst  (i_rst),
    .i_en   (tk),
    .i_sig  (i_external_reset_trigger),
    .o_rise (rise),
    .o_fall (fall)
  );

  // reset level and qualifying edge per mode
  always_comb begin
    case (mode_e)
      // RULE_01: low-reset codes
      HLT_M_LVL_LO, HLT_M_LEO_LO, HLT_M_LOS_LO: rst_lvl = ~i_external_reset_trigger;
      default: rst_lvl = i_external_reset_trigger;
    endcase
    case (mode_e)
      HLT_M_EOS_R, HLT_M_EHL_R, HLT_M_MONO_R, HLT_M_LEO_LO: edge_sel = rise;
      HLT_M_EOS_F, HLT_M_EHL_F, HLT_M_MONO_F, HLT_M_LEO_HI: edge_sel = fall;
      default: edge_sel = rise | fall;
    endcase
  end

  // per-mode next state of the counter, run flag and delays
  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    hold_d = hold_q;
    asrt_d = asrt_q;
    clr_on = 1'b0;
    pwm_go = 1'b0;
    adv    = 1'b0;
    idle   = 1'b0;
    case (mode_e)
      HLT_M_LVL_LO, HLT_M_LVL_HI: begin
        // RULE_02: trigger ignored while off
        if (on_q && rst_lvl) begin
          asrt_d = (asrt_q == HOLD_TICKS) ? HOLD_TICKS : asrt_q + 2'h1;
          // RULE_03: clear two clocks into reset
          if (asrt_d == HOLD_TICKS) begin
            cnt_d  = '0;
            hold_d = HOLD_TICKS;
          end else begin
            adv = 1'b1;
          end
        end else if (on_q) begin
          asrt_d = 2'h0;
          // RULE_04: resume two clocks after release
          if (hold_q != 2'h0) begin
            hold_d = hold_q - 2'h1;
            pwm_go = hold_q == 2'h1;
          end else begin
            adv = 1'b1;
          end
        end
        // RULE_05: restart at period, pwm also set here
        pwm_go = pwm_go | (adv & match);
      end
      HLT_M_SW: begin
        // RULE_08: clearing on just pauses
        adv = on_q;
        // RULE_07: drive starts with a fresh set
        pwm_go = on_q & ~on_prev_q & (cnt_q == '0);
        // RULE_06: match ends the shot
        clr_on = adv & match;
      end
      HLT_M_EOS_R, HLT_M_EOS_F, HLT_M_EOS_A, HLT_M_MONO_R, HLT_M_MONO_F, HLT_M_MONO_A: begin
        // RULE_10: halting drops the start, a new edge is needed
        if (!on_q) begin
          run_d = 1'b0;
        // RULE_09: start on selected edge
        // RULE_16: monostable edge start
        end else if (!run_q && edge_sel) begin
          run_d = 1'b1;
          // RULE_18: only the start edge drives pwm
          pwm_go = 1'b1;
        end
        adv = on_q & run_q;
        if (adv && match) begin
          run_d = 1'b0;
          // RULE_17: monostable halts at zero, on kept
          clr_on = mode_q[4] == 1'b0;
        end
      end
      HLT_M_EHL_R, HLT_M_EHL_F: begin
        // RULE_12: edges ignored while off
        if (!on_q) begin
          run_d = 1'b0;
        end else if (edge_sel) begin
          // RULE_11: first edge starts, later edges reset
          run_d  = 1'b1;
          // RULE_13: every such edge starts pwm
          pwm_go = 1'b1;
          if (run_q) begin
            cnt_d  = '0;
            hold_d = HOLD_TICKS - 2'h1;
          end
        end else if (run_q) begin
          if (hold_q != 2'h0) begin
            hold_d = hold_q - 2'h1;
          end else begin
            adv = 1'b1;
          end
        end
        if (adv && match) begin
          run_d  = 1'b0;
          clr_on = 1'b1;
        end
      end
      HLT_M_LEO_LO, HLT_M_LEO_HI: begin
        // RULE_14: held at the reset level
        if (rst_lvl) begin
          cnt_d = '0;
          run_d = 1'b0;
        end else if (!on_q) begin
          run_d = 1'b0;
        // RULE_15: start edge needed, pwm on the edge
        end else if (!run_q && edge_sel) begin
          run_d  = 1'b1;
          pwm_go = 1'b1;
        end
        adv = on_q & run_q & ~rst_lvl;
        if (adv && match) begin
          run_d  = 1'b0;
          clr_on = 1'b1;
        end
      end
      HLT_M_LOS_LO, HLT_M_LOS_HI: begin
        // RULE_19: held reset until on and released
        if (rst_lvl || !on_q) begin
          cnt_d = '0;
          run_d = 1'b0;
        end else if (!run_q) begin
          run_d  = 1'b1;
          // RULE_21: whichever event came last starts pwm
          pwm_go = 1'b1;
        end
        adv = on_q & run_q & ~rst_lvl;
        // RULE_20: match clears on, back to held
        if (adv && match) begin
          run_d  = 1'b0;
          clr_on = 1'b1;
        end
      end
      default: begin
        // RULE_24: reserved codes stay idle
        cnt_d  = '0;
        run_d  = 1'b0;
        hold_d = 2'h0;
        asrt_d = 2'h0;
        idle   = 1'b1;
      end
    endcase
    if (adv) begin
      cnt_d = match ? '0 : cnt_q + 1'b1;
    end
  end

  // timer state advances on timer ticks only
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q     <= '0;
      run_q     <= 1'b0;
      hold_q    <= 2'h0;
      asrt_q    <= 2'h0;
      on_prev_q <= 1'b0;
    end else if (tk) begin
      cnt_q     <= cnt_d;
      run_q     <= run_d;
      hold_q    <= hold_d;
      asrt_q    <= asrt_d;
      on_prev_q <= on_q;
    end
  end

  // on bit: a software write wins over the hardware clear
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      on_q <= 1'b0;
    end else if (ctrl_on_wr) begin
      on_q <= wdata_q[CTRL_ON_BIT];
    // RULE_06: hardware clear at match
    end else if (tk && clr_on) begin
      on_q <= 1'b0;
    end
  end

  hlt_pwm_drive #(.W(W)) u_pwm (
    .i_clk   (i_sys_clk),
    .i_rst   (i_rst),
    .i_en    (tk),
    .i_start (pwm_go),
    .i_adv   (adv),
    .i_kill  (idle),
    .i_count (cnt_q),
    .i_cmp   (pulse_width_compare_q),
    .o_drive (o_pwm_drive)
  );

  // RULE_23: keep the chosen oscillator alive in sleep
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_keep_low_freq_internal_osc  <= 1'b0;
      o_keep_mid_freq_internal_osc  <= 1'b0;
      o_keep_high_freq_internal_osc <= 1'b0;
    end else if (i_clk_en) begin
      o_keep_low_freq_internal_osc  <= i_sleep & ~prescaler_sync_enable_q & (clk_src_q == CLK_LOW);
      o_keep_mid_freq_internal_osc  <= i_sleep & ~prescaler_sync_enable_q & (clk_src_q == CLK_MID);
      o_keep_high_freq_internal_osc <= i_sleep & ~prescaler_sync_enable_q & (clk_src_q == CLK_HIGH);
    end
  end

  // write channels taken in either order, applied when both are held
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else if (i_clk_en) begin
      o_awready <= ~aw_full_q & ~(i_awvalid & o_awready) & ~o_bvalid;
      o_wready  <= ~w_full_q & ~(i_wvalid & o_wready) & ~o_bvalid;
      if (i_awvalid && o_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_full_q <= 1'b1;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        o_bvalid  <= 1'b1;
        o_bresp   <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_PERIOD ||
                      awaddr_q == ADDR_PWCMP) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // writable registers, by byte lane
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q                <= MODE_RST;
      prescaler_sync_enable_q               <= 1'b0;
      clk_src_q             <= CLK_OTHER;
      period_value_q        <= W'(PERIOD_RST);
      pulse_width_compare_q <= W'(PWCMP_RST);
    end else if (do_wr) begin
      if (awaddr_q == ADDR_CTRL && wstrb_q[1]) begin
        mode_q <= wdata_q[CTRL_MODE_LSB +: 5];
      end
      if (awaddr_q == ADDR_CTRL && wstrb_q[2]) begin
        prescaler_sync_enable_q   <= wdata_q[CTRL_PRESCALER_SYNC_ENABLE_BIT];
        clk_src_q <= wdata_q[CTRL_CLK_LSB +: 2];
      end
      if (awaddr_q == ADDR_PERIOD && wstrb_q[0]) begin
        period_value_q <= wdata_q[W-1:0];
      end
      if (awaddr_q == ADDR_PWCMP && wstrb_q[0]) begin
        pulse_width_compare_q <= wdata_q[W-1:0];
      end
    end
  end

  // read data mux
  always_comb begin
    rd_d = 32'h0;
    case (i_araddr)
      ADDR_CTRL: begin
        rd_d[CTRL_ON_BIT]          = on_q;
        rd_d[CTRL_MODE_LSB +: 5]   = mode_q;
        rd_d[CTRL_PRESCALER_SYNC_ENABLE_BIT]       = prescaler_sync_enable_q;
        rd_d[CTRL_CLK_LSB +: 2]    = clk_src_q;
      end
      ADDR_PERIOD: rd_d[W-1:0] = period_value_q;
      ADDR_PWCMP:  rd_d[W-1:0] = pulse_width_compare_q;
      ADDR_COUNT:  rd_d[W-1:0] = cnt_q;
      ADDR_STATUS: begin
        rd_d[STAT_RUN_BIT]  = run_q;
        rd_d[STAT_PWM_BIT]  = o_pwm_drive;
        rd_d[STAT_ERS_BIT]  = i_external_reset_trigger;
        rd_d[STAT_HOLD_BIT] = hold_q != 2'h0;
      end
      default: rd_d = 32'h0;
    endcase
  end

  // read channel, one transfer at a time
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0;
      o_rresp   <= RESP_OKAY;
    end else if (i_clk_en) begin
      o_arready <= ~(i_arvalid & o_arready) & ~o_rvalid;
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata  <= rd_d;
        o_rresp  <= (i_araddr <= ADDR_STATUS && i_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  lvl_clear_a: assert property ( // RULE_03
    tk && (mode_e == HLT_M_LVL_LO || mode_e == HLT_M_LVL_HI) && on_q && rst_lvl
    && asrt_q >= 2'h1 |=> cnt_q == '0)
    else $error("level limit did not clear after two clocks");
  lvl_ignore_a: assert property ( // RULE_02
    tk && (mode_e == HLT_M_LVL_LO || mode_e == HLT_M_LVL_HI) && !on_q |=> $stable(cnt_q))
    else $error("level limit moved while off");
  lvl_resume_a: assert property ( // RULE_04
    tk && (mode_e == HLT_M_LVL_LO || mode_e == HLT_M_LVL_HI) && on_q && !rst_lvl
    && hold_q == 2'h1 |=> o_pwm_drive)
    else $error("pwm not raised two clocks after release");
  sw_end_a: assert property ( // RULE_06
    tk && mode_e == HLT_M_SW && on_q && match && !ctrl_on_wr |=> !on_q && cnt_q == '0)
    else $error("one shot did not end at period match");
  eos_rearm_a: assert property ( // RULE_10
    tk && (mode_e == HLT_M_EOS_R || mode_e == HLT_M_EOS_F || mode_e == HLT_M_EOS_A)
    && !on_q |=> !run_q)
    else $error("edge one shot kept running while off");
  ehl_reset_a: assert property ( // RULE_11
    tk && (mode_e == HLT_M_EHL_R || mode_e == HLT_M_EHL_F) && on_q && run_q && edge_sel
    |=> cnt_q == '0 && hold_q == 2'h1)
    else $error("reset edge did not restart the count");
  mono_halt_a: assert property ( // RULE_17
    tk && mode_q[4:2] == 3'b100 && adv && match && !ctrl_on_wr
    |=> cnt_q == '0 && !run_q && on_q)
    else $error("monostable did not halt at zero with on kept");
  los_hold_a: assert property ( // RULE_19
    tk && (mode_e == HLT_M_LOS_LO || mode_e == HLT_M_LOS_HI) && rst_lvl |=> cnt_q == '0)
    else $error("level one shot not held at reset level");
  sleep_freeze_a: assert property ( // RULE_22
    i_clk_en && i_sleep && prescaler_sync_enable_q |=> $stable(cnt_q))
    else $error("count moved in sleep with sync set");
  rsvd_idle_a: assert property ( // RULE_24
    tk && idle |=> cnt_q == '0 && !o_pwm_drive)
    else $error("reserved mode not idle");
endmodule // hlt_timer
`default_nettype wire

// ---- tb/hlt_trig_model.sv ----
// far-side logic that drives the external reset/trigger level
// assumes the bench asks for a level; the output moves on the clock
`timescale 1ns/10ps
`default_nettype none
module hlt_trig_model (
  // clock and requested level
  input  wire logic i_clk,
  input  wire logic i_level,
  // trigger to the timer
  output logic      o_trigger
);
  // registered so the trigger stays synchronous to the timer
  always_ff @(posedge i_clk) begin
    o_trigger <= i_level;
  end
endmodule // hlt_trig_model
`default_nettype wire

// ---- tb/test_hardware_limit_timer_modes.sv ----
// bench for the hardware limit timer: axi4-lite tasks and mode scenarios
// assumes the trigger model sits on the external reset/trigger input
`timescale 1ns/10ps
`default_nettype none
module test_hardware_limit_timer_modes;
  import hlt_pkg::*;
  logic        clk = 0, rst = 1, tick = 0, sleep = 0, lvl = 0, trig;
  logic [7:0]  awaddr = 0, araddr = 0, cnt, hold;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, pwm, on, klo, kmi, khi;
  logic [1:0]  bresp, rresp, resp;
  int          err_count = 0, checked = 0, i;
  // 250 mhz system clock
  always #2 clk = ~clk;
  hlt_trig_model u_trig (.i_clk(clk), .i_level(lvl), .o_trigger(trig));
  hlt_timer dut (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(1'b1),
    .i_timer_tick(tick), .i_sleep(sleep), .i_external_reset_trigger(trig),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_pwm_drive(pwm), .o_count_value(cnt), .o_on(on),
    .o_keep_low_freq_internal_osc(klo), .o_keep_mid_freq_internal_osc(kmi),
    .o_keep_high_freq_internal_osc(khi)
  );
  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic late;
    err_count++;
    $display("[FAIL] %0t bus wait ran out", $time);
    test_done();
  endtask
  // write: aw and w offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) late();
    resp = bresp;
    bready <= 1'b0;
  endtask
  // read: rready held until rvalid is seen
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 40) late();
    rd_q = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // timer clocks as one-cycle enables, one every other cycle
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    // one more edge so the last tick's results are read settled
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(logic o, logic [4:0] m, logic [31:0] x);
    return x | 32'(o) | (32'(m) << CTRL_MODE_LSB);
  endfunction
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL);
    chk(rd_q, 32'h0);
    rd(ADDR_PERIOD);
    chk(rd_q, 32'h0000_00ff);
    rd(8'h14);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(ADDR_COUNT, 32'h5);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    // edge one shot: no edge, then a rising edge
    wr(ADDR_PERIOD, 32'h2);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_EOS_R, 32'h0));
    tk(2);
    chk(cnt, 8'h00);
    lvl <= 1'b1;
    tk(3);
    chk(cnt, 8'h02);
    tk(1);
    chk(on, 1'b0);
    // on set again with trigger still high: waits for an edge
    wr(ADDR_CTRL, cw(1'b1, HLT_M_EOS_R, 32'h0));
    tk(3);
    chk(cnt, 8'h00);
    // monostable halts at zero, on kept
    lvl <= 1'b0;
    // edges are seen against the last tick, so the low level needs a tick
    tk(1);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_MONO_R, 32'h0));
    lvl <= 1'b1;
    tk(3);
    chk(cnt, 8'h02);
    tk(1);
    chk({cnt, on}, 9'h001);
    tk(2);
    chk(cnt, 8'h00);
    // software one shot runs to match and clears on
    wr(ADDR_PERIOD, 32'h4);
    wr(ADDR_PWCMP, 32'h3);
    // on must be seen low on a tick before a fresh set starts the drive
    wr(ADDR_CTRL, cw(1'b0, HLT_M_SW, 32'h0));
    tk(1);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_SW, 32'h0));
    tk(1);
    chk(pwm, 1'b1);
    // clearing on mid-cycle pauses the count and keeps the drive
    wr(ADDR_CTRL, cw(1'b0, HLT_M_SW, 32'h0));
    tk(2);
    chk({pwm, cnt}, 9'h101);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_SW, 32'h0));
    for (i = 0; i < 20 && on; i++) tk(1);
    chk({on, pwm, cnt}, 10'h000);
    // level limit, reset on high level
    wr(ADDR_PERIOD, 32'hff);
    lvl <= 1'b1;
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LVL_HI, 32'h0));
    tk(4);
    chk(cnt, 8'h00);
    lvl <= 1'b0;
    tk(6);
    chk(32'(cnt != 8'h00), 32'h1);
    // sleep with prescaler sync set freezes the count
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LVL_HI, 32'h1 << CTRL_PRESCALER_SYNC_ENABLE_BIT));
    sleep <= 1'b1;
    hold = cnt;
    tk(4);
    chk(cnt, hold);
    // sync clear with low osc: keeps running in sleep
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LVL_HI, 32'(CLK_LOW) << CTRL_CLK_LSB));
    tk(2);
    chk(32'(cnt != hold), 32'h1);
    chk(klo, 1'b1);
    chk({kmi, khi}, 2'h0);
    sleep <= 1'b0;
    // reserved code stays idle
    wr(ADDR_CTRL, cw(1'b1, 5'h00, 32'h0));
    tk(4);
    chk({cnt, pwm}, 9'h000);
    // edge limit one shot: a later rising edge restarts the count
    wr(ADDR_CTRL, cw(1'b1, HLT_M_EHL_R, 32'h0));
    lvl <= 1'b1;
    tk(3);
    chk({pwm, cnt}, 9'h102);
    lvl <= 1'b0;
    tk(1);
    lvl <= 1'b1;
    tk(1);
    chk({pwm, cnt}, 9'h100);
    tk(2);
    chk(cnt, 8'h01);
    tk(3);
    chk({pwm, cnt}, 9'h004);
    // level one shot: held at low level, started by its release
    lvl <= 1'b0;
    wr(ADDR_PERIOD, 32'h2);
    wr(ADDR_PWCMP, 32'h1);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LOS_LO, 32'h0));
    tk(2);
    chk(cnt, 8'h00);
    lvl <= 1'b1;
    tk(1);
    chk(pwm, 1'b1);
    tk(3);
    chk({on, pwm, cnt}, 10'h000);
    // level reset edge one shot: falling edge out of the high level starts
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LEO_HI, 32'h0));
    lvl <= 1'b0;
    tk(1);
    chk(pwm, 1'b1);
    tk(3);
    chk({on, pwm, cnt}, 10'h000);
    wr(ADDR_CTRL, cw(1'b1, HLT_M_LEO_HI, 32'h0));
    tk(2);
    chk(cnt, 8'h00);
    test_done();
  end
endmodule // test_hardware_limit_timer_modes
`default_nettype wire
